// >>> logic/sw1m_map.svh
`ifndef SW1M_MAP_SVH
`define SW1M_MAP_SVH
// clock period and ns to cycles, rounded up
`define SW1M_CLK_NS 4
`define SW1M_CYC(t) (((t) + `SW1M_CLK_NS - 1) / `SW1M_CLK_NS)
// register byte offsets
`define SW1M_A_CFG 8'h00
`define SW1M_A_CMD 8'h04
`define SW1M_A_TXD 8'h08
`define SW1M_A_RXD 8'h0c
`define SW1M_A_STAT 8'h10
`define SW1M_A_IRAW 8'h14
`define SW1M_A_IMSK 8'h18
`define SW1M_A_IMIS 8'h1c
`define SW1M_A_DMA 8'h20
// config bits
`define SW1M_C_OD 0
`define SW1M_C_LATE 1
`define SW1M_C_NOPD 2
`define SW1M_C_INV 3
`define SW1M_C_TWO 4
// command bits and bit count field
`define SW1M_K_RST 0
`define SW1M_K_WR 1
`define SW1M_K_RD 2
`define SW1M_K_NL 8
`define SW1M_K_NH 13
// status bits
`define SW1M_S_BUSY 0
`define SW1M_S_NOSL 1
`define SW1M_S_STK 2
// interrupt bits
`define SW1M_I_RSTD 0
`define SW1M_I_OPD 1
`define SW1M_I_NOSL 2
`define SW1M_I_STK 3
`define SW1M_I_DMAD 4
// dma control bits
`define SW1M_D_RST 0
`define SW1M_D_RDE 1
`define SW1M_D_MWR 2
`define SW1M_D_MRD 3
`define SW1M_D_SG 4
`define SW1M_D_SZL 5
`define SW1M_D_SZH 6
`define SW1M_SZ_BYTE 2'h0
`define SW1M_SZ_HALF 2'h1
`define SW1M_NB_BYTE 6'h08
`define SW1M_NB_HALF 6'h10
`define SW1M_NB_WORD 6'h20
// reset values
`define SW1M_RXD_RST 32'hffffffff
`define SW1M_CFG_RST 5'h00
`define SW1M_MSK_RST 5'h00
`define SW1M_DMA_RST 7'h00
// bus times in ns
`define SW1M_RSTL_STD_NS 480000
`define SW1M_RSTL_OD_NS 48000
`define SW1M_PRES_STD_NS 70000
`define SW1M_PRES_OD_NS 8000
`define SW1M_RSTE_STD_NS 960000
`define SW1M_RSTE_OD_NS 96000
`define SW1M_SLOT_STD_NS 70000
`define SW1M_SLOT_OD_NS 10000
`define SW1M_LOW0_STD_NS 60000
`define SW1M_LOW0_OD_NS 7500
`define SW1M_LOW1_STD_NS 6000
`define SW1M_LOW1_OD_NS 1000
`define SW1M_SMP_STD_NS 15000
`define SW1M_SMP_OD_NS 2000
`define SW1M_LATE_STD_NS 30000
`define SW1M_LATE_OD_NS 4000
`define SW1M_STUCK_NS 1000000
`endif

// >>> logic/sw1m_pkg.sv
package sw1m_pkg;
    // sequencer states
    typedef enum logic [2:0] {
        SW1M_IDLE = 3'b001,
        SW1M_RESET = 3'b010,
        SW1M_SLOT = 3'b100
    } sw1m_state_e;
    // wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } sw1m_wb_req_s;
    // wire pins towards the slaves
    typedef struct packed {
        logic dq;
        logic dq_oe;
        logic tx;
    } sw1m_pin_s;
endpackage

// >>> logic/sw1m_sync.sv
`timescale 1ns/100ps
module sw1m_sync #(
    parameter int W = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    import sw1m_pkg::*;
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sw1m_sync_s;
    sw1m_sync_s s_reg;
    sw1m_sync_s s_next;

    // first stage is read only by the second
    always_comb begin
        s_next = s_reg;
        s_next.s1 = d_i;
        s_next.s2 = s_reg.s1;
    end

    // idle bus reads high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q_o = s_reg.s2;
endmodule

// >>> logic/sw1m_timer.sv
`timescale 1ns/100ps
module sw1m_timer #(
    parameter int TW = 18
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [TW-1:0] low_i,
    input wire logic [TW-1:0] smp_i,
    input wire logic [TW-1:0] end_i,
    output logic low_o,
    output logic smp_o,
    output logic end_o
);
    import sw1m_pkg::*;
    typedef struct packed {
        logic act;
        logic [TW-1:0] cnt;
    } sw1m_tmr_s;
    sw1m_tmr_s t_reg;
    sw1m_tmr_s t_next;

    // a start restarts the count even in the last cycle
    always_comb begin
        t_next = t_reg;
        if (start_i) begin
            t_next.act = 1'b1;
            t_next.cnt = '0;
        end else if (t_reg.act) begin
            if (t_reg.cnt == end_i) begin
                t_next.act = 1'b0;
            end else begin
                t_next.cnt = t_reg.cnt + TW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    // window flags, thresholds are live
    assign low_o = t_reg.act & (t_reg.cnt < low_i);
    assign smp_o = t_reg.act & (t_reg.cnt == smp_i);
    assign end_o = t_reg.act & (t_reg.cnt == end_i);
endmodule

// >>> logic/sw1m_top.sv
// Function
// - a reset command drives a reset pulse on the wire
// - busy shows while reset, read or write is running
// - no-slave status set when reset saw no presence pulse
// - stuck status while someone else holds the line low
// - read bits default to one, silent slave reads all ones
// - standard or overdrive slot timing selectable
// - read sample point standard or late
// - presence check after reset on or off
// - normal or inverted pin polarity
// - one two-way data pin or two separate pins
// - dma reset option issues bus reset before scatter-gather or dma read sequence
// - dma read requested after each finished transaction
// - chained writes or reads launch the next of same type
// - scatter-gather requests on enable and each completion
// - dma transfers are 8, 16 or 32 bits
// - reset-complete interrupt when reset ends
// - op-complete interrupt after write, or after read if both
// - no-presence interrupt when no slave answered
// - stuck-bus interrupt when line held low by other
// - dma-complete interrupt when dma sequence ends
// - software clears sources, cleared sources drop
// - only enabled sources reach the interrupt output
// - raw and masked status both readable
// - transaction of 1 to 32 bits, optional leading reset
// - write phase finishes before read phase
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`include "sw1m_map.svh"
module sw1m_top #(
    parameter int TW = 18,
    parameter int RSTL_STD = `SW1M_CYC(`SW1M_RSTL_STD_NS),
    parameter int RSTL_OD = `SW1M_CYC(`SW1M_RSTL_OD_NS),
    parameter int PRES_STD = `SW1M_CYC(`SW1M_PRES_STD_NS),
    parameter int PRES_OD = `SW1M_CYC(`SW1M_PRES_OD_NS),
    parameter int RSTE_STD = `SW1M_CYC(`SW1M_RSTE_STD_NS),
    parameter int RSTE_OD = `SW1M_CYC(`SW1M_RSTE_OD_NS),
    parameter int SLOT_STD = `SW1M_CYC(`SW1M_SLOT_STD_NS),
    parameter int SLOT_OD = `SW1M_CYC(`SW1M_SLOT_OD_NS),
    parameter int LOW0_STD = `SW1M_CYC(`SW1M_LOW0_STD_NS),
    parameter int LOW0_OD = `SW1M_CYC(`SW1M_LOW0_OD_NS),
    parameter int LOW1_STD = `SW1M_CYC(`SW1M_LOW1_STD_NS),
    parameter int LOW1_OD = `SW1M_CYC(`SW1M_LOW1_OD_NS),
    parameter int SMP_STD = `SW1M_CYC(`SW1M_SMP_STD_NS),
    parameter int SMP_OD = `SW1M_CYC(`SW1M_SMP_OD_NS),
    parameter int LATE_STD = `SW1M_CYC(`SW1M_LATE_STD_NS),
    parameter int LATE_OD = `SW1M_CYC(`SW1M_LATE_OD_NS),
    parameter int STUCK_CYC = `SW1M_CYC(`SW1M_STUCK_NS)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input sw1m_pkg::sw1m_wb_req_s wb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic dq_i,
    input wire logic rx_i,
    output sw1m_pkg::sw1m_pin_s pins_o,
    input wire logic dma_done_i,
    output logic dma_req_o,
    output logic irq_o
);
    import sw1m_pkg::*;

    typedef struct packed {
        sw1m_state_e st;
        logic [4:0] cfg;
        logic [6:0] dma;
        logic [31:0] txd;
        logic [31:0] rxd;
        logic do_wr;
        logic do_rd;
        logic rd_ph;
        logic [5:0] nbits;
        logic [5:0] bidx;
        logic pres;
        logic noslv;
        logic stuck;
        logic [TW-1:0] lowcnt;
        logic drv;
        logic dpend;
        logic dreq;
        logic [4:0] iraw;
        logic [4:0] imsk;
        logic irq;
        logic ack;
        logic [31:0] rdat;
        sw1m_pin_s pins;
    } sw1m_top_s;

    sw1m_top_s s_reg;
    sw1m_top_s s_next;
    logic [1:0] pin_sync;
    logic ln;
    logic od;
    logic tstart;
    logic tlow;
    logic tsmp;
    logic tend;
    logic [TW-1:0] t_low;
    logic [TW-1:0] t_smp;
    logic [TW-1:0] t_end;
    logic go;
    logic g_rst;
    logic g_wr;
    logic g_rd;
    logic [5:0] g_n;
    logic fin;
    logic rfin;
    logic wr;
    logic [4:0] iset;
    logic [4:0] iclr;
    logic [31:0] wd;
    logic [5:0] cn;

    // byte-lane merge of a bus write
    function automatic logic [31:0] wmerge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // dma transfer size to bit count
    function automatic logic [5:0] dsz(input logic [1:0] sz);
        logic [5:0] r;
        r = `SW1M_NB_WORD;
        if (sz == `SW1M_SZ_BYTE) begin
            r = `SW1M_NB_BYTE;
        end else if (sz == `SW1M_SZ_HALF) begin
            r = `SW1M_NB_HALF;
        end
        return r;
    endfunction

    // both wire inputs cross into the clock domain
    sw1m_sync #(
        .W(2)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({rx_i, dq_i}),
        .q_o(pin_sync)
    );

    // line is low when pin equals the drive level
    assign ln = (s_reg.cfg[`SW1M_C_TWO] ? pin_sync[1] : pin_sync[0])
        == s_reg.cfg[`SW1M_C_INV];

    assign od = s_reg.cfg[`SW1M_C_OD];

    // slot and reset timing by speed
    always_comb begin
        if (s_reg.st == SW1M_RESET) begin
            t_low = od ? TW'(RSTL_OD) : TW'(RSTL_STD);
            t_smp = od ? TW'(RSTL_OD + PRES_OD) : TW'(RSTL_STD + PRES_STD);
            t_end = od ? TW'(RSTE_OD - 1) : TW'(RSTE_STD - 1);
        end else begin
            if (!s_reg.rd_ph && !s_reg.txd[s_reg.bidx[4:0]]) begin
                t_low = od ? TW'(LOW0_OD) : TW'(LOW0_STD);
            end else begin
                t_low = od ? TW'(LOW1_OD) : TW'(LOW1_STD);
            end
            if (s_reg.cfg[`SW1M_C_LATE]) begin
                t_smp = od ? TW'(LATE_OD) : TW'(LATE_STD);
            end else begin
                t_smp = od ? TW'(SMP_OD) : TW'(SMP_STD);
            end
            t_end = od ? TW'(SLOT_OD - 1) : TW'(SLOT_STD - 1);
        end
    end

    // one timer serves reset and bit slots
    sw1m_timer #(
        .TW(TW)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(tstart),
        .low_i(t_low),
        .smp_i(t_smp),
        .end_i(t_end),
        .low_o(tlow),
        .smp_o(tsmp),
        .end_o(tend)
    );

    // bus slave, sequencer, dma pacing and interrupt status
    always_comb begin
        s_next = s_reg;
        s_next.dreq = 1'b0;
        tstart = 1'b0;
        go = 1'b0;
        g_rst = 1'b0;
        g_wr = 1'b0;
        g_rd = 1'b0;
        g_n = `SW1M_NB_WORD;
        fin = 1'b0;
        rfin = 1'b0;
        iset = '0;
        iclr = '0;
        wd = 32'h0;
        cn = wb_i.dat[`SW1M_K_NH:`SW1M_K_NL];

        // one ack per request, dropped the cycle after
        s_next.ack = wb_i.cyc & wb_i.stb & ~s_reg.ack;
        wr = s_next.ack & wb_i.we;
        if (s_next.ack && !wb_i.we) begin
            case (wb_i.adr)
                `SW1M_A_CFG: s_next.rdat = {27'h0, s_reg.cfg};
                `SW1M_A_CMD: s_next.rdat = {18'h0, s_reg.nbits, 5'h0,
                    s_reg.do_rd, s_reg.do_wr, s_reg.st == SW1M_RESET};
                `SW1M_A_TXD: s_next.rdat = s_reg.txd;
                // no guard, software reads when idle
                `SW1M_A_RXD: s_next.rdat = s_reg.rxd;
                `SW1M_A_STAT: s_next.rdat = {29'h0, s_reg.stuck,
                    s_reg.noslv, s_reg.st != SW1M_IDLE};
                `SW1M_A_IRAW: s_next.rdat = {27'h0, s_reg.iraw};
                `SW1M_A_IMSK: s_next.rdat = {27'h0, s_reg.imsk};
                `SW1M_A_IMIS: s_next.rdat = {27'h0, s_reg.iraw & s_reg.imsk};
                `SW1M_A_DMA: s_next.rdat = {25'h0, s_reg.dma};
                default: s_next.rdat = 32'h0;
            endcase
        end

        // register writes
        if (wr) begin
            case (wb_i.adr)
                `SW1M_A_CFG: begin
                    wd = wmerge({27'h0, s_reg.cfg}, wb_i.dat, wb_i.sel);
                    s_next.cfg = wd[4:0];
                end
                `SW1M_A_CMD: begin
                    // commands while busy are dropped
                    if (s_reg.st == SW1M_IDLE) begin
                        // count 1 to 32, 0 or over means 32
                        go = 1'b1;
                        g_rst = wb_i.dat[`SW1M_K_RST];
                        g_wr = wb_i.dat[`SW1M_K_WR];
                        g_rd = wb_i.dat[`SW1M_K_RD];
                        g_n = (cn == 6'h00 || cn > `SW1M_NB_WORD) ?
                            `SW1M_NB_WORD : cn;
                    end
                end
                `SW1M_A_TXD: begin
                    s_next.txd = wmerge(s_reg.txd, wb_i.dat, wb_i.sel);
                    // dma data write starts the next write
                    if (s_reg.st == SW1M_IDLE && s_reg.dma[`SW1M_D_MWR]) begin
                        go = 1'b1;
                        g_wr = 1'b1;
                        g_n = dsz(s_reg.dma[`SW1M_D_SZH:`SW1M_D_SZL]);
                    end
                end
                `SW1M_A_IRAW: begin
                    wd = wmerge(32'h0, wb_i.dat, wb_i.sel);
                    iclr = wd[4:0];
                end
                `SW1M_A_IMSK: begin
                    wd = wmerge({27'h0, s_reg.imsk}, wb_i.dat, wb_i.sel);
                    s_next.imsk = wd[4:0];
                end
                `SW1M_A_DMA: begin
                    wd = wmerge({25'h0, s_reg.dma}, wb_i.dat, wb_i.sel);
                    s_next.dma = wd[6:0];
                    if (s_reg.st == SW1M_IDLE) begin
                        if (wd[`SW1M_D_RST] && (wd[`SW1M_D_SG] || wd[`SW1M_D_MRD])) begin
                            // bus reset first, the start waits for it
                            go = 1'b1;
                            g_rst = 1'b1;
                            s_next.dpend = 1'b1;
                        end else begin
                            s_next.dreq = wd[`SW1M_D_SG];
                            if (wd[`SW1M_D_MRD]) begin
                                go = 1'b1;
                                g_rd = 1'b1;
                                g_n = dsz(wd[`SW1M_D_SZH:`SW1M_D_SZL]);
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // wire sequencer
        case (s_reg.st)
            SW1M_IDLE: begin
            end
            SW1M_RESET: begin
                if (tsmp && ln) begin
                    s_next.pres = 1'b1;
                end
                if (tend) begin
                    iset[`SW1M_I_RSTD] = 1'b1;
                    s_next.noslv = ~s_reg.pres & ~s_reg.cfg[`SW1M_C_NOPD];
                    iset[`SW1M_I_NOSL] = s_next.noslv;
                    if (s_reg.do_wr || s_reg.do_rd) begin
                        s_next.st = SW1M_SLOT;
                        s_next.bidx = 6'h00;
                        tstart = 1'b1;
                        if (!s_reg.do_wr) begin
                            s_next.rxd = `SW1M_RXD_RST;
                        end
                    end else begin
                        s_next.st = SW1M_IDLE;
                        rfin = 1'b1;
                    end
                end
            end
            SW1M_SLOT: begin
                if (tsmp && s_reg.rd_ph) begin
                    s_next.rxd[s_reg.bidx[4:0]] = ~ln;
                end
                if (tend) begin
                    if (s_reg.bidx != s_reg.nbits - 6'h01) begin
                        s_next.bidx = s_reg.bidx + 6'h01;
                        tstart = 1'b1;
                    end else if (!s_reg.rd_ph && s_reg.do_rd) begin
                        s_next.rd_ph = 1'b1;
                        s_next.bidx = 6'h00;
                        s_next.rxd = `SW1M_RXD_RST;
                        tstart = 1'b1;
                    end else begin
                        // op done after the last phase
                        s_next.st = SW1M_IDLE;
                        fin = 1'b1;
                        iset[`SW1M_I_OPD] = 1'b1;
                    end
                end
            end
            default: begin
                s_next.st = SW1M_IDLE;
            end
        endcase

        if (fin && (|s_reg.dma[`SW1M_D_SG:`SW1M_D_RDE])) begin
            s_next.dreq = 1'b1;
        end
        if (fin && s_reg.dma[`SW1M_D_MRD] && s_reg.rd_ph) begin
            go = 1'b1;
            g_rd = 1'b1;
            g_n = dsz(s_reg.dma[`SW1M_D_SZH:`SW1M_D_SZL]);
        end
        // held dma start after the reset
        if (rfin && s_reg.dpend) begin
            s_next.dpend = 1'b0;
            s_next.dreq = s_reg.dma[`SW1M_D_SG];
            if (s_reg.dma[`SW1M_D_MRD]) begin
                go = 1'b1;
                g_rd = 1'b1;
                g_n = dsz(s_reg.dma[`SW1M_D_SZH:`SW1M_D_SZL]);
            end
        end
        iset[`SW1M_I_DMAD] = dma_done_i;

        // launch a transaction
        if (go && (g_rst || g_wr || g_rd)) begin
            s_next.st = g_rst ? SW1M_RESET : SW1M_SLOT;
            s_next.do_wr = g_wr;
            s_next.do_rd = g_rd;
            s_next.nbits = g_n;
            s_next.rd_ph = ~g_wr;
            s_next.bidx = 6'h00;
            s_next.pres = 1'b0;
            tstart = 1'b1;
            if (!g_rst && !g_wr) begin
                s_next.rxd = `SW1M_RXD_RST;
            end
        end

        // pins follow the drive window, registered
        s_next.drv = (s_reg.st != SW1M_IDLE) & tlow;
        s_next.pins.dq = s_next.cfg[`SW1M_C_INV];
        s_next.pins.dq_oe = s_next.drv & ~s_next.cfg[`SW1M_C_TWO];
        s_next.pins.tx = (s_next.drv & s_next.cfg[`SW1M_C_TWO]) ?
            s_next.cfg[`SW1M_C_INV] : ~s_next.cfg[`SW1M_C_INV];

        // line low while we release it, long enough to rule
        // out a presence pulse
        if (ln && !s_reg.drv) begin
            if (s_reg.lowcnt != TW'(STUCK_CYC)) begin
                s_next.lowcnt = s_reg.lowcnt + TW'(1);
            end
        end else begin
            s_next.lowcnt = '0;
        end
        s_next.stuck = s_next.lowcnt == TW'(STUCK_CYC);
        iset[`SW1M_I_STK] = s_next.stuck & ~s_reg.stuck;

        // sticky, set beats a same-cycle clear
        s_next.iraw = (s_reg.iraw & ~iclr) | iset;
        // only enabled sources reach the output
        s_next.irq = |(s_next.iraw & s_next.imsk);
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.st <= SW1M_IDLE;
            s_reg.cfg <= `SW1M_CFG_RST;
            s_reg.dma <= `SW1M_DMA_RST;
            s_reg.imsk <= `SW1M_MSK_RST;
            s_reg.rxd <= `SW1M_RXD_RST;
            s_reg.nbits <= `SW1M_NB_WORD;
            s_reg.pins.tx <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_dat_o = s_reg.rdat;
    assign wb_ack_o = s_reg.ack;
    assign pins_o = s_reg.pins;
    assign dma_req_o = s_reg.dreq;
    assign irq_o = s_reg.irq;
endmodule

// >>> test/sw1m_props.sv
`timescale 1ns/100ps
module sw1m_props #(
    parameter int RSTL = 40,
    parameter int LOW0 = 24,
    parameter int LOW1 = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input sw1m_pkg::sw1m_wb_req_s wb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input sw1m_pkg::sw1m_pin_s pins_o,
    input wire logic dma_req_o,
    input wire logic irq_o
);
    import sw1m_pkg::*;
    int low_cnt_reg;
    // length of the current drive-low stretch
    always_ff @(posedge clk_i) begin
        low_cnt_reg <= (rst_i || !pins_o.dq_oe) ? 0 : low_cnt_reg + 1;
    end
    sequence req_s;
        wb_i.cyc && wb_i.stb && !wb_ack_o;
    endsequence
    ack_follows_a: assert property (@(posedge clk_i) disable iff (rst_i) req_s |=> wb_ack_o)
        else $error("request not acked next cycle");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    unmapped_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && !wb_i.we && wb_i.adr == 8'h30 |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    // a low stretch is a reset pulse, a zero slot or a one/read slot
    low_len_a: assert property (@(posedge clk_i) disable iff (rst_i) $fell(pins_o.dq_oe) |->
        (low_cnt_reg == RSTL || low_cnt_reg == LOW0 || low_cnt_reg == LOW1)) else $error("bad low length");
    recovery_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(pins_o.dq_oe) |-> !pins_o.dq_oe [*6]) else $error("slot recovery too short");
    dma_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) dma_req_o |=> !dma_req_o)
        else $error("dma request longer than one cycle");
    // reset checks need the reset cycle itself, so no disable here
    rst_quiet_a: assert property (@(posedge clk_i) rst_i |=> !wb_ack_o && !pins_o.dq_oe && !irq_o)
        else $error("outputs active after reset");
    rst_pins_a: assert property (@(posedge clk_i) rst_i |=> pins_o.tx && !pins_o.dq && !dma_req_o)
        else $error("pin levels wrong after reset");
endmodule
bind sw1m_top sw1m_props #(.RSTL(RSTL_STD), .LOW0(LOW0_STD), .LOW1(LOW1_STD)) props_u (.clk_i(clk_i),
    .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_o(pins_o),
    .dma_req_o(dma_req_o), .irq_o(irq_o));

// >>> test/sw1m_slave.sv
`timescale 1ns/100ps
module sw1m_slave (
    input wire logic clk_i,
    input wire logic line_i,
    input wire logic present_i,
    input wire logic zeros_i,
    input wire logic hold_i,
    output logic pull_o,
    output logic [31:0] bits_o
);
    int low_reg;
    int pull_reg;
    assign pull_o = hold_i || (pull_reg != 0);
    // time the master's low, answer once it lets go; long low means reset
    always_ff @(posedge clk_i) begin
        low_reg <= (!line_i && !pull_o) ? low_reg + 1 : 0;
        if (pull_reg != 0) begin
            pull_reg <= pull_reg - 1;
        end else if (line_i && low_reg >= 30 && present_i) begin
            pull_reg <= 15;
        end else if (line_i && low_reg > 0 && low_reg < 10 && zeros_i) begin
            pull_reg <= 15;
        end
        // each short low the master made is one bit, shifted in from the top, lsb first
        if (line_i && low_reg > 0 && low_reg < 30) begin
            bits_o <= {low_reg < 10, bits_o[31:1]};
        end
    end
endmodule

// >>> test/tb.sv
`timescale 1ns/100ps
module tb;
    import sw1m_pkg::*;
    logic clk_i = 0;
    logic rst_i = 1;
    sw1m_wb_req_s wb_i = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    sw1m_pin_s pins_o;
    logic dma_done_i = 0;
    logic dma_req_o, irq_o, line, pull, seen_req;
    logic [31:0] wbits;
    // shortened bus times so a run stays short
    localparam int RSTL = 40, PRES = 10, RSTE = 100, SLOT = 30, LOW0 = 24, LOW1 = 4, SMP = 8, LATE = 14, STK = 300;
    logic present = 1, zeros = 0, hold = 0;
    int errors = 0;
    int tests_run = 0;
    logic [31:0] d;
    // open-drain wire with pull-up; the two-pin transmit output pulls the same wire
    assign line = (pins_o.dq_oe ? pins_o.dq : 1'b1) && pins_o.tx && !pull;
    sw1m_top #(.RSTL_STD(RSTL), .PRES_STD(PRES), .RSTE_STD(RSTE), .SLOT_STD(SLOT), .LOW0_STD(LOW0),
        .LOW1_STD(LOW1), .SMP_STD(SMP), .LATE_STD(LATE), .STUCK_CYC(STK)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dq_i(line), .rx_i(line), .pins_o(pins_o),
        .dma_done_i(dma_done_i), .dma_req_o(dma_req_o), .irq_o(irq_o));
    sw1m_slave slave_u (.clk_i(clk_i), .line_i(line), .present_i(present), .zeros_i(zeros),
        .hold_i(hold), .pull_o(pull), .bits_o(wbits));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // remember any dma request pulse
    always @(posedge clk_i) begin
        seen_req <= rst_i ? 1'b0 : (seen_req || dma_req_o);
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        wb_i <= '{1'b1, 1'b1, we, a, 4'hf, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            test_done();
        end
        d = wb_dat_o;
        wb_i <= '0;
        @(posedge clk_i);
    endtask
    task automatic idle;
        int n;
        n = 0;
        do begin
            bus(1'b0, 8'h10, 32'h0);
            n++;
        end while (d[0] !== 1'b0 && n < 400);
        if (n >= 400) begin
            errors++;
            test_done();
        end
    endtask
    task automatic s_regs;
        bus(1'b0, 8'h0c, 32'h0);
        chk("rxd", d, 32'hffffffff);
        bus(1'b0, 8'h30, 32'h0);
        chk("unmapped", d, 32'h0);
        bus(1'b0, 8'h18, 32'h0);
        chk("mask", d, 32'h0);
    endtask
    task automatic s_reset(input logic p, input logic [31:0] cfg);
        present <= p;
        bus(1'b1, 8'h00, cfg);
        bus(1'b1, 8'h04, 32'h1);
        bus(1'b0, 8'h10, 32'h0);
        chk("busy", d & 32'h1, 32'h1);
        idle();
        bus(1'b0, 8'h14, 32'h0);
        chk("raw", d, (p || cfg[2]) ? 32'h1 : 32'h5);
        bus(1'b0, 8'h10, 32'h0);
        chk("noslave", d & 32'h2, (p || cfg[2]) ? 32'h0 : 32'h2);
        bus(1'b1, 8'h18, 32'h4);
        repeat (2) @(posedge clk_i);
        chk("irq", {31'h0, irq_o}, {31'h0, !(p || cfg[2])});
        bus(1'b0, 8'h1c, 32'h0);
        chk("masked", d, (p || cfg[2]) ? 32'h0 : 32'h4);
        bus(1'b1, 8'h14, 32'h1f);
        bus(1'b0, 8'h14, 32'h0);
        chk("cleared", d, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("irq off", {31'h0, irq_o}, 32'h0);
        bus(1'b1, 8'h00, 32'h0);
    endtask
    task automatic s_read(input logic z);
        zeros <= z;
        bus(1'b1, 8'h08, 32'ha5);
        bus(1'b1, 8'h04, 32'h0806);
        idle();
        bus(1'b0, 8'h0c, 32'h0);
        chk("rxd", d, z ? 32'hffffff00 : 32'hffffffff);
        chk("wire bits", wbits & 32'hffff0000, 32'hffa50000);
        bus(1'b0, 8'h14, 32'h0);
        chk("opdone", d & 32'h2, 32'h2);
        bus(1'b1, 8'h14, 32'h1f);
        zeros <= 1'b0;
    endtask
    task automatic s_stuck;
        hold <= 1'b1;
        repeat (STK + 20) @(posedge clk_i);
        bus(1'b0, 8'h10, 32'h0);
        chk("stuck", d & 32'h4, 32'h4);
        bus(1'b0, 8'h14, 32'h0);
        chk("stuck raw", d & 32'h8, 32'h8);
        hold <= 1'b0;
        repeat (4) @(posedge clk_i);
        bus(1'b0, 8'h10, 32'h0);
        chk("unstuck", d & 32'h4, 32'h0);
    endtask
    task automatic s_dma;
        bus(1'b1, 8'h20, 32'h10);
        repeat (4) @(posedge clk_i);
        chk("sg req", {31'h0, seen_req}, 32'h1);
        dma_done_i <= 1'b1;
        @(posedge clk_i);
        dma_done_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        bus(1'b0, 8'h14, 32'h0);
        chk("dma done", d & 32'h10, 32'h10);
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        s_regs();
        s_reset(1'b1, 32'h0);
        s_reset(1'b0, 32'h0);
        s_reset(1'b0, 32'h4);
        s_reset(1'b1, 32'h10);
        present <= 1'b1;
        s_read(1'b0);
        s_read(1'b1);
        s_stuck();
        s_dma();
        test_done();
    end
endmodule
